// file: rtl/sdvd_consts.svh
`ifndef SDVD_CONSTS_SVH
`define SDVD_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register map, reset values and timing counts
// ----------------------------------------------------------------------------
`define SDVD_ADDR_CTRL        8'h00
`define SDVD_ADDR_STAT        8'h04
`define SDVD_ADDR_ERR         8'h08
`define SDVD_ADDR_ISTAT       8'h0c
`define SDVD_ADDR_IMASK       8'h10
`define SDVD_ADDR_LTHR        8'h14
`define SDVD_CTRL_FLUSH_BIT   8
`define SDVD_CTRL_RST         6'h00
`define SDVD_LTHR_RST         10'h030
`define SDVD_IMASK_RST        3'h0
`define SDVD_NUM_STATES       64
`define SDVD_PATH_DEPTH       80
`define SDVD_ERR_WIN_LAST     10'h3ff
`define SDVD_ERR_MAX          8'hff
// ----------------------------------------------------------------------------
// Puncture masks, bit n is code step n of the period
// ----------------------------------------------------------------------------
`define SDVD_P34_KEEP0        7'h05
`define SDVD_P34_KEEP1        7'h03
`define SDVD_P34_LAST         3'h2
`define SDVD_P78_KEEP0        7'h51
`define SDVD_P78_KEEP1        7'h2f
`define SDVD_P78_LAST         3'h6
// ----------------------------------------------------------------------------
// Soft symbol metric bases and interrupt bit positions
// ----------------------------------------------------------------------------
`define SDVD_SYM_MATCH_BASE   3'h4
`define SDVD_SYM_MISS_BASE    3'h3
`define SDVD_SYM_ERASED       3'h0
`define SDVD_IRQ_LOCK_UP      0
`define SDVD_IRQ_LOCK_DOWN    1
`define SDVD_IRQ_WINDOW       2
`endif

// file: rtl/sdvd_pkg.sv
package sdvd_pkg;
  // --------------------------------------------------------------------------
  // Shared types
  // --------------------------------------------------------------------------
  // One soft decision: sign is the hard bit, mag the confidence.
  typedef struct packed {
    logic       sign;
    logic [1:0] mag;
  } sdvd_sym_t;
  // One code symbol pair as presented by the demodulator.
  typedef struct packed {
    sdvd_sym_t second_code_symbol;
    sdvd_sym_t first_code_symbol;
  } sdvd_pair_t;
  // Control register layout, rate in the low bits.
  typedef struct packed {
    logic [1:0] rot;
    logic       diff_en;
    logic       desc_en;
    logic [1:0] rate;
  } sdvd_ctrl_t;
  // Code rates.
  typedef enum logic [1:0] {rate_half, rate_3_4, rate_7_8} sdvd_rate_t;
endpackage

// file: rtl/sdvd_top.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "sdvd_consts.svh"
module sdvd_top
  import sdvd_pkg::*;
#(
  parameter int unsigned MW        = 10,       // State metric width.
  parameter logic [6:0]  GEN0      = 7'h79,    // First code generator.
  parameter logic [6:0]  GEN1      = 7'h5b,    // Second code generator.
  parameter int unsigned DSC_LEN   = 23,       // Descrambler register length.
  parameter int unsigned DSC_TAP_A = 17,       // Descrambler feedback taps.
  parameter int unsigned DSC_TAP_B = 22
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sym_valid_i,
  input  wire sdvd_pair_t  sym_pair_i,
  output logic             sym_ready_o,
  output logic             dec_bit_o,
  output logic             dec_valid_o,
  output logic             lock_o,
  output logic      [7:0]  raw_err_o,
  output logic             irq_o
);
  // --------------------------------------------------------------------------
  // Constants and helper functions
  // --------------------------------------------------------------------------
  localparam int unsigned NS    = `SDVD_NUM_STATES;
  localparam int unsigned DEPTH = `SDVD_PATH_DEPTH;
  localparam logic [6:0]  P34K0 = `SDVD_P34_KEEP0;
  localparam logic [6:0]  P34K1 = `SDVD_P34_KEEP1;
  localparam logic [6:0]  P78K0 = `SDVD_P78_KEEP0;
  localparam logic [6:0]  P78K1 = `SDVD_P78_KEEP1;

  // Metric of one soft symbol against an expected code bit; erased counts 0.
  function automatic logic [2:0] sym_metric(sdvd_sym_t s, logic exp_bit, logic erased);
    if (erased) begin
      return `SDVD_SYM_ERASED;
    end else if (s.sign == exp_bit) begin
      return `SDVD_SYM_MATCH_BASE + {1'b0, s.mag};
    end else begin
      return `SDVD_SYM_MISS_BASE - {1'b0, s.mag};
    end
  endfunction

  // Branch metric for one trellis branch, larger means more likely.
  function automatic logic [3:0] branch_metric(logic [6:0] enc, sdvd_sym_t s0, sdvd_sym_t s1,
                                               logic er0, logic er1);
    return {1'b0, sym_metric(s0, ^(enc & GEN0), er0)} + {1'b0, sym_metric(s1, ^(enc & GEN1), er1)};
  endfunction

  // Rotates a pair by a multiple of 90 degrees; a sign flip negates a symbol.
  function automatic sdvd_pair_t rotate(sdvd_pair_t p, logic [1:0] rot);
    sdvd_pair_t r;
    r = p;
    case (rot)
      2'h1: begin
        r.first_code_symbol  = '{~p.second_code_symbol.sign, p.second_code_symbol.mag};
        r.second_code_symbol = p.first_code_symbol;
      end
      2'h2: begin
        r.first_code_symbol  = '{~p.first_code_symbol.sign, p.first_code_symbol.mag};
        r.second_code_symbol = '{~p.second_code_symbol.sign, p.second_code_symbol.mag};
      end
      2'h3: begin
        r.first_code_symbol  = p.second_code_symbol;
        r.second_code_symbol = '{~p.first_code_symbol.sign, p.first_code_symbol.mag};
      end
      default: r = p;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // APB slave and registers
  // --------------------------------------------------------------------------
  sdvd_ctrl_t  ctrl_q;                 // Rate, stage enables, rotation.
  logic [MW-1:0] lthr_q;               // Lock threshold on metric spread.
  logic [2:0]  imask_q;                // Interrupt mask.
  logic [2:0]  istat_q, istat_d;       // Sticky interrupt status.
  logic        pready_q, pslverr_q;    // Bus answer flops.
  logic [31:0] prdata_q, rdata_w;      // Read data and its mux.
  logic        lock_q, full_w;         // Lock and path-full state.
  logic [7:0]  raw_err_q;              // Last completed window count.
  logic [2:0]  irq_ev;                 // Events of this cycle.
  logic        irq_q;                  // Registered interrupt line.

  wire setup_w  = psel_i & ~penable_i;
  wire access_w = psel_i & penable_i & pready_q;
  wire wr_w     = access_w & pwrite_i;
  wire hit_ctrl = paddr_i == `SDVD_ADDR_CTRL;
  wire hit_stat = paddr_i == `SDVD_ADDR_STAT;
  wire hit_err  = paddr_i == `SDVD_ADDR_ERR;
  wire hit_ist  = paddr_i == `SDVD_ADDR_ISTAT;
  wire hit_imk  = paddr_i == `SDVD_ADDR_IMASK;
  wire hit_lthr = paddr_i == `SDVD_ADDR_LTHR;
  wire hit_any  = hit_ctrl | hit_stat | hit_err | hit_ist | hit_imk | hit_lthr;
  wire [2:0] ist_clr = (wr_w & hit_ist) ? pwdata_i[2:0] : 3'h0;
  wire [1:0] new_rate = pwdata_i[1:0];
  // A rate change or soft reset flushes the whole trellis.
  wire flush_w = wr_w & hit_ctrl & (pwdata_i[`SDVD_CTRL_FLUSH_BIT] | (new_rate != ctrl_q.rate));

  // Read mux; unmapped addresses read zero and raise pslverr.
  assign rdata_w = hit_ctrl ? {26'h0, ctrl_q} :
                   hit_stat ? {30'h0, full_w, lock_q} :
                   hit_err  ? {24'h0, raw_err_q} :
                   hit_ist  ? {29'h0, istat_q} :
                   hit_imk  ? {29'h0, imask_q} :
                   hit_lthr ? {{(32-MW){1'b0}}, lthr_q} : 32'h0;
  // Set wins over a write-one clear in the same cycle.
  assign istat_d = (istat_q & ~ist_clr) | irq_ev;

  // Bus answer: every access takes exactly one access cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~hit_any;
      prdata_q  <= (setup_w & ~pwrite_i) ? rdata_w : 32'h0;
    end
  end

  // Software registers; writes land at the access edge only.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q  <= `SDVD_CTRL_RST;
      lthr_q  <= MW'(`SDVD_LTHR_RST);
      imask_q <= `SDVD_IMASK_RST;
      istat_q <= 3'h0;
      irq_q   <= 1'b0;
    end else begin
      if (wr_w & hit_ctrl) begin
        ctrl_q <= pwdata_i[5:0];
      end
      if (wr_w & hit_lthr) begin
        lthr_q <= pwdata_i[MW-1:0];
      end
      if (wr_w & hit_imk) begin
        imask_q <= pwdata_i[2:0];
      end
      istat_q <= istat_d;
      irq_q   <= |(istat_d & imask_q);
    end
  end

  // --------------------------------------------------------------------------
  // Ambiguity resolver and depuncturing buffer
  // --------------------------------------------------------------------------
  sdvd_sym_t  sb_q [4];                // Symbol queue, oldest at index 0.
  sdvd_sym_t  sb_d [4];
  sdvd_sym_t  ext_w [6];               // Queue extended by the new pair.
  logic [2:0] cnt_q, cnt_d;            // Symbols held, zero to four.
  logic [2:0] pidx_q;                  // Position in the puncture period.
  logic       ready_q;                 // Registered input ready.
  logic       keep0, keep1;            // Symbols present at this step.

  wire sdvd_rate_t rate_w = sdvd_rate_t'(ctrl_q.rate);
  wire sdvd_pair_t rot_w  = rotate(sym_pair_i, ctrl_q.rot);
  wire acc_w    = sym_valid_i & ready_q;
  wire [2:0] last_w = (rate_w == rate_3_4) ? `SDVD_P34_LAST : (rate_w == rate_7_8) ? `SDVD_P78_LAST : 3'h0;

  // Puncture mask lookup; rate 1/2 keeps both symbols every step.
  always_comb begin
    case (rate_w)
      rate_3_4: begin
        keep0 = P34K0[pidx_q];
        keep1 = P34K1[pidx_q];
      end
      rate_7_8: begin
        keep0 = P78K0[pidx_q];
        keep1 = P78K1[pidx_q];
      end
      default: begin
        keep0 = 1'b1;
        keep1 = 1'b1;
      end
    endcase
  end

  wire [2:0] need_w = {2'b0, keep0} + {2'b0, keep1};
  wire       step_w = ~flush_w & (cnt_q >= need_w);
  wire [2:0] take_w = step_w ? need_w : 3'h0;
  // Missing positions are re-inserted as erasures.
  wire sdvd_sym_t s0_w = sb_q[0];
  wire sdvd_sym_t s1_w = keep0 ? sb_q[1] : sb_q[0];

  // Queue update: append the accepted pair, drop what the step consumed.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      if (k < 4 && k < int'(cnt_q)) begin
        ext_w[k] = sb_q[k];
      end else if (k == int'(cnt_q)) begin
        ext_w[k] = rot_w.first_code_symbol;
      end else if (k == int'(cnt_q) + 1) begin
        ext_w[k] = rot_w.second_code_symbol;
      end else begin
        ext_w[k] = '0;
      end
    end
    for (int i = 0; i < 4; i++) begin
      sb_d[i] = ext_w[i + int'(take_w)];
    end
    cnt_d = cnt_q - take_w + (acc_w ? 3'h2 : 3'h0);
  end

  // Queue flops; ready only while two free places remain after this cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sb_q    <= '{default: '0};
      cnt_q   <= 3'h0;
      pidx_q  <= 3'h0;
      ready_q <= 1'b0;
    end else if (flush_w) begin
      cnt_q   <= 3'h0;
      pidx_q  <= 3'h0;
      ready_q <= 1'b0;
    end else begin
      sb_q    <= sb_d;
      cnt_q   <= cnt_d;
      ready_q <= cnt_d <= 3'h2;
      if (step_w) begin
        pidx_q <= (pidx_q >= last_w) ? 3'h0 : pidx_q + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Add-compare-select over 64 states with register-exchange paths
  // --------------------------------------------------------------------------
  logic [MW-1:0]    pm_q   [NS];       // State metrics, larger is better.
  logic [MW-1:0]    pm_d   [NS];
  logic [DEPTH-1:0] path_q [NS];       // Survivor decisions per state.
  logic [DEPTH-1:0] path_d [NS];
  logic [MW-1:0]    pm_max, pm_min;    // Extremes of the current metrics.
  logic [5:0]       best;              // State holding the largest metric.
  logic [6:0]       fill_q;            // Steps stored so far, up to DEPTH.

  // Each new state has two predecessors differing in their oldest bit.
  for (genvar ns = 0; ns < NS; ns++) begin : g_acs
    localparam logic [5:0] NSV = 6'(ns);
    localparam logic [5:0] PR0 = {NSV[4:0], 1'b0};
    localparam logic [5:0] PR1 = {NSV[4:0], 1'b1};
    wire [3:0]    bm0 = branch_metric({NSV[5], PR0}, s0_w, s1_w, ~keep0, ~keep1);
    wire [3:0]    bm1 = branch_metric({NSV[5], PR1}, s0_w, s1_w, ~keep0, ~keep1);
    // Subtracting the old minimum keeps metrics from overflowing.
    wire [MW-1:0] c0  = pm_q[PR0] + MW'(bm0) - pm_min;
    wire [MW-1:0] c1  = pm_q[PR1] + MW'(bm1) - pm_min;
    wire          dec = c1 > c0;
    assign pm_d[ns]   = dec ? c1 : c0;
    assign path_d[ns] = dec ? {path_q[PR1][DEPTH-2:0], NSV[5]} : {path_q[PR0][DEPTH-2:0], NSV[5]};
  end

  // Metric extremes and the survivor state.
  always_comb begin
    pm_max = pm_q[0];
    pm_min = pm_q[0];
    best   = 6'h0;
    for (int s = 1; s < NS; s++) begin
      if (pm_q[s] > pm_max) begin
        pm_max = pm_q[s];
        best   = 6'(s);
      end
      if (pm_q[s] < pm_min) begin
        pm_min = pm_q[s];
      end
    end
  end

  // Trellis flops; a flush restarts from equal metrics and empty paths.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pm_q   <= '{default: '0};
      path_q <= '{default: '0};
      fill_q <= 7'h0;
    end else if (flush_w) begin
      pm_q   <= '{default: '0};
      path_q <= '{default: '0};
      fill_q <= 7'h0;
    end else if (step_w) begin
      pm_q   <= pm_d;
      path_q <= path_d;
      if (!full_w) begin
        fill_q <= fill_q + 7'h1;
      end
    end
  end

  assign full_w = fill_q == 7'(DEPTH);

  // --------------------------------------------------------------------------
  // Output chain, lock judgement and raw error count
  // --------------------------------------------------------------------------
  logic [DSC_LEN-1:0] dsc_q;           // Received bits for descrambling.
  logic               diff_q;          // Previous descrambled bit.
  logic               out_bit_q, out_vld_q;
  logic [MW-1:0]      spread_q;        // Spread at the previous step.
  logic [9:0]         win_q;           // Samples in the current window.
  logic [7:0]         errs_q;          // Errors in the current window.

  wire          rel_w  = step_w & full_w;
  wire          raw_w  = path_q[best][DEPTH-1];
  wire [MW-1:0] spread = pm_max - pm_min;
  wire          dsc_w  = ctrl_q.desc_en ? raw_w ^ dsc_q[DSC_TAP_A] ^ dsc_q[DSC_TAP_B] : raw_w;
  wire          dif_w  = ctrl_q.diff_en ? dsc_w ^ diff_q : dsc_w;
  wire          lock_w = spread >= lthr_q;
  // A shrinking spread means the best path lost ground to a symbol error.
  wire          err_w  = spread < spread_q;
  wire          wend_w = rel_w & (win_q == `SDVD_ERR_WIN_LAST);
  wire [7:0]    errs_n = (err_w && errs_q != `SDVD_ERR_MAX) ? errs_q + 8'h1 : errs_q;

  assign irq_ev[`SDVD_IRQ_LOCK_UP]   = rel_w & lock_w & ~lock_q;
  assign irq_ev[`SDVD_IRQ_LOCK_DOWN] = (rel_w & ~lock_w & lock_q) | (flush_w & lock_q);
  assign irq_ev[`SDVD_IRQ_WINDOW]    = wend_w;

  // Serial output stages, advanced once per released bit.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dsc_q     <= '0;
      diff_q    <= 1'b0;
      out_bit_q <= 1'b0;
      out_vld_q <= 1'b0;
    end else begin
      out_vld_q <= rel_w;
      if (rel_w) begin
        dsc_q     <= {dsc_q[DSC_LEN-2:0], raw_w};
        diff_q    <= dsc_w;
        out_bit_q <= dif_w;
      end
    end
  end

  // Lock and error window; both restart on a flush.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_q    <= 1'b0;
      spread_q  <= '0;
      win_q     <= 10'h0;
      errs_q    <= 8'h0;
      raw_err_q <= 8'h0;
    end else if (flush_w) begin
      lock_q    <= 1'b0;
      spread_q  <= '0;
      win_q     <= 10'h0;
      errs_q    <= 8'h0;
      raw_err_q <= 8'h0;
    end else if (rel_w) begin
      lock_q   <= lock_w;
      spread_q <= spread;
      win_q    <= win_q + 10'h1;
      errs_q   <= wend_w ? 8'h0 : errs_n;
      if (wend_w) begin
        raw_err_q <= errs_n;
      end
    end
  end

  assign prdata_o    = prdata_q;
  assign pready_o    = pready_q;
  assign pslverr_o   = pslverr_q;
  assign sym_ready_o = ready_q;
  assign dec_bit_o   = out_bit_q;
  assign dec_valid_o = out_vld_q;
  assign lock_o      = lock_q;
  assign raw_err_o   = raw_err_q;
  assign irq_o       = irq_q;

  // --------------------------------------------------------------------------
  // Assertions and covers
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  flush_clears_lock_a: assert property (flush_w |=> !lock_o && fill_q == 7'h0)
    else $error("Flush did not clear lock and path memory.");
  depth_gate_a: assert property (dec_valid_o |-> $past(fill_q) == 7'(DEPTH))
    else $error("Bit released before the path memory was full.");
  window_wrap_a: assert property (wend_w |=> win_q == 10'h0 && raw_err_o == $past(errs_n))
    else $error("Error window did not close after 1024 samples.");
  pair_taken_a: assert property (acc_w && !flush_w |=> cnt_q >= 3'h2)
    else $error("Accepted symbol pair not held.");
  half_no_erase_a: assert property (step_w && rate_w == rate_half |-> keep0 && keep1)
    else $error("Erasure inserted at rate one half.");
  survivor_max_a: assert property (pm_q[best] == pm_max)
    else $error("Survivor is not the largest metric.");
  lock_judged_a: assert property (rel_w |=> lock_o == ($past(spread) >= $past(lthr_q)))
    else $error("Lock does not follow the metric spread.");
  pass_through_a: assert property (rel_w && !ctrl_q.desc_en && !ctrl_q.diff_en |=> dec_bit_o == $past(raw_w))
    else $error("Deselected stages altered the data.");

  lock_seen_c:   cover property (rel_w && lock_w && !lock_q);
  rate78_out_c:  cover property (dec_valid_o && rate_w == rate_7_8);
  window_done_c: cover property (wend_w);
endmodule

// file: tb/sdvd_demod_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Demodulator model: encodes random bits into soft symbol pairs.
// ----------------------------------------------------------------
module sdvd_demod_model
  import sdvd_pkg::*;
#(
  parameter logic [6:0] GEN0 = 7'h79, // First code generator.
  parameter logic [6:0] GEN1 = 7'h5b  // Second code generator.
) (
  input  wire logic  core_clk_i,
  input  wire logic  arst_n_i,
  input  wire logic  run_i,
  input  wire logic  flip_i,
  input  wire logic  sym_ready_i,
  output logic       sym_valid_o,
  output sdvd_pair_t sym_pair_o,
  output logic       bit_o
);
  logic [5:0] st;                // Encoder shift state.
  logic       b;                 // Bit about to be offered.
  int         seed = 32'h7777ea9a; // Fixed seed for a repeatable run.
  // An offer is held until taken; while run_i is low the pair lines toggle so stale data never looks fresh.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st = 6'h00;
      sym_valid_o <= 1'b0;
      sym_pair_o <= '0;
      bit_o <= 1'b0;
    end else if (!sym_valid_o || sym_ready_i) begin
      if (sym_valid_o) st = {bit_o, st[5:1]};
      b = 1'($random(seed));
      bit_o <= b;
      sym_valid_o <= run_i && (($random(seed) & 3) != 0);
      if (run_i) begin
        // A half-turn of the carrier inverts both signs; the decoder must undo it.
        sym_pair_o <= {^({b, st} & GEN1), 2'($random(seed)), ^({b, st} & GEN0), 2'($random(seed))}
                      ^ (flip_i ? 6'h24 : 6'h00);
      end else begin
        sym_pair_o <= ~sym_pair_o;
      end
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "sdvd_consts.svh"
// ----------------------------------------------------------------
// Bench: APB master, bit model and scenario sequence.
// ----------------------------------------------------------------
module testbench
  import sdvd_pkg::*;
;
  logic        core_clk_i, arst_n_i, psel, penable, pwrite, run;
  logic [7:0]  paddr, raw_err;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, sym_valid, sym_ready, src_bit;
  logic        dec_bit, dec_valid, lock, irq, diff_on, prev, b0;
  logic        desc_on, flip, d0;  // Descrambler expected on, source half-turn, descrambled bit.
  logic [22:0] hist;               // Decoded raw bits, newest at bit 0.
  sdvd_pair_t  pair;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          nbits = 0;  // Decoded bits seen so far.
  logic        exp_q[$];   // Bits sent and not yet decoded.
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  sdvd_top dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sym_valid_i(sym_valid), .sym_pair_i(pair), .sym_ready_o(sym_ready),
    .dec_bit_o(dec_bit), .dec_valid_o(dec_valid), .lock_o(lock), .raw_err_o(raw_err), .irq_o(irq));
  sdvd_demod_model u_src (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .run_i(run), .flip_i(flip),
    .sym_ready_i(sym_ready), .sym_valid_o(sym_valid), .sym_pair_o(pair), .bit_o(src_bit));
  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the slave's latency is not assumed, only bounded.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_bits(input int n);
    int k;
    k = 0;
    n = n + nbits;
    while (nbits < n && k < 20000) begin
      @(posedge core_clk_i);
      k++;
    end
    if (k >= 20000) begin
      error_cnt++;
      conclude();
    end
  endtask
  // Reference model: a clean channel must give back the sent bits in order.
  always @(posedge core_clk_i) begin
    if (sym_valid === 1'b1 && sym_ready === 1'b1) exp_q.push_back(src_bit);
    if (dec_valid === 1'b1) begin
      chk(32'(exp_q.size() >= 80), 32'h1);
      if (exp_q.size() > 0) begin
        b0 = exp_q.pop_front();
        // Self-synchronising descrambler first, then the differential stage.
        d0 = desc_on ? b0 ^ hist[17] ^ hist[22] : b0;
        chk(32'(dec_bit), 32'(diff_on ? d0 ^ prev : d0));
        prev = d0;
        hist = {hist[21:0], b0};
      end
      nbits++;
    end
  end
  // Scenario sequence.
  initial begin
    arst_n_i = 1'b0;
    {psel, penable, pwrite, run, diff_on, desc_on, prev, flip} = 8'h00;
    hist = 23'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, `SDVD_ADDR_CTRL, 32'h0);
    chk(rd, 32'(`SDVD_CTRL_RST));
    apb(1'b0, `SDVD_ADDR_LTHR, 32'h0);
    chk(rd, 32'(`SDVD_LTHR_RST));
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    diff_on = 1'b1;
    desc_on = 1'b1;
    apb(1'b1, `SDVD_ADDR_CTRL, 32'h0c);
    apb(1'b1, `SDVD_ADDR_IMASK, 32'h1);
    // A low threshold keeps a clean channel steadily locked; the spread swings with symbol confidence.
    apb(1'b1, `SDVD_ADDR_LTHR, 32'h4);
    run <= 1'b1;
    wait_bits(300);
    chk(32'(lock), 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, `SDVD_ADDR_ISTAT, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk(32'(irq), 32'h0);
    apb(1'b1, `SDVD_ADDR_IMASK, 32'h2);
    apb(1'b1, `SDVD_ADDR_LTHR, 32'h3ff);
    wait_bits(4);
    chk({30'h0, lock, irq}, 32'h1);
    // Flush with the source paused, so no sent bit is lost unseen.
    run <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    apb(1'b1, `SDVD_ADDR_CTRL, 32'h120);
    diff_on = 1'b0;
    desc_on = 1'b0;
    exp_q.delete();
    @(posedge core_clk_i);
    chk({22'h0, sym_ready, lock, raw_err}, 32'h0);
    apb(1'b1, `SDVD_ADDR_LTHR, 32'h4);
    flip <= 1'b1;
    run <= 1'b1;
    wait_bits(200);
    chk(32'(lock), 32'h1);
    // Run past one full error window of released bits.
    wait_bits(830);
    apb(1'b0, `SDVD_ADDR_ISTAT, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b0, `SDVD_ADDR_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `SDVD_ADDR_ERR, 32'h0);
    chk(rd, {24'h0, raw_err});
    conclude();
  end
endmodule
